// ==== testbench/fea_switch_model.sv ====
// Purpose: Behavioural switch mechanism driving the position sensors.
// Assumes: A go pulse moves between source one and source two.
// Notes:   Stall holds the switch at neutral to force a slow leg.
`timescale 1ns/100ps
`default_nettype none
module fea_switch_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic go,
  input  wire logic stall,
  output logic      pos_source1,
  output logic      pos_neutral,
  output logic      pos_source2
);
  logic [1:0] pos;
  logic [1:0] dest;
  logic [2:0] dly;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos <= 2'h0;
      dest <= 2'h0;
      dly <= 3'h0;
    end else if (go) begin
      dest <= (pos == 2'h0) ? 2'h2 : 2'h0;
      dly <= 3'h3;
    end else if (dly != 3'h0) begin
      dly <= dly - 3'h1;
    end else if (pos != dest && pos != 2'h1) begin
      pos <= 2'h1;
      dly <= 3'h3;
    end else if (pos == 2'h1 && !stall) begin
      pos <= dest;
    end
  end
  assign pos_source1 = (pos == 2'h0);
  assign pos_neutral = (pos == 2'h1);
  assign pos_source2 = (pos == 2'h2);
endmodule
`default_nettype wire

// ==== testbench/fea_top_bench.sv ====
// Purpose: Self-checking bench for the fault event annunciator.
// Assumes: Mask bits enable the interrupt; flash counts are shortened.
// Notes:   Each fault input is raised, checked, acknowledged and cleared.
`timescale 1ns/100ps
`default_nettype none
module fea_top_bench;
  localparam logic [7:0] ST = 8'(fea_pkg::REG_OFS_STATUS);
  localparam logic [7:0] MK = 8'(fea_pkg::REG_OFS_MASK);
  localparam logic [7:0] AC = 8'(fea_pkg::REG_OFS_ACTIVE);
  localparam logic [7:0] FT = 8'(fea_pkg::REG_OFS_FTC);
  localparam logic [7:0] HC = 8'(fea_pkg::REG_OFS_HCOUNT);
  localparam logic [7:0] HS = 8'(fea_pkg::REG_OFS_HSEL);
  localparam logic [7:0] HD = 8'(fea_pkg::REG_OFS_HDATA);
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, status_led, fault_message, asterisk, irq, err;
  logic [6:0]  ev = '0;
  logic        xs = 0, rxs = 0, stall = 0, rbtn = 0, obtn = 0, s1, nt, s2;
  int          miscompares = 0, cmp_count = 0;
  int          bits[5] = '{fea_pkg::F_CHKSUM, fea_pkg::F_CTLBAT, fea_pkg::F_CHARGER,
                           fea_pkg::F_NETBAT, fea_pkg::F_NETCOM};
  always #2.5 pclk = ~pclk;
  fea_top #(.CODE_GAP_CYCLES(24), .DIGIT_GAP_CYCLES(12), .PULSE_ON_CYCLES(4),
    .PULSE_OFF_CYCLES(4), .BLINK_CYCLES(8)) u_fea_top (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .checksum_done(ev[0]),
    .checksum_mismatch(ev[0]), .ctl_battery_low(ev[1]), .charger_fault(ev[4]),
    .network_link_module_batt_low(ev[5]), .network_link_module_comm_lost(ev[6]),
    .pos_source1(s1), .pos_neutral(nt), .pos_source2(s2), .transfer_start(xs),
    .retransfer_start(rxs), .reset_button(rbtn), .override_button(obtn),
    .status_led(status_led), .fault_message(fault_message), .asterisk(asterisk), .irq(irq));
  fea_switch_model u_fea_switch_model (.pclk(pclk), .presetn(presetn), .go(xs | rxs),
    .stall(stall), .pos_source1(s1), .pos_neutral(nt), .pos_source2(s2));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic press(input logic o);
    if (o) obtn <= 1;
    else rbtn <= 1;
    repeat (2) @(posedge pclk);
    obtn <= 0;
    rbtn <= 0;
    repeat (4) @(posedge pclk);
  endtask
  task automatic t_reset();
    apb(0, FT, 0);
    chk(rd, fea_pkg::FTC_RESET);
    chk(32'(err), 0);
    apb(0, 8'h40, 0);
    chk(32'(err), 1);
    apb(1, FT, 32'd20);
    apb(1, MK, 32'hff);
    apb(0, ST, 0);
    chk(rd, 0);
    $display("test reset done");
  endtask
  task automatic t_events();
    int b;
    foreach (bits[i]) begin
      b = bits[i];
      ev[b] <= 1;
      repeat (10) @(posedge pclk);
      apb(0, ST, 0);
      chk(rd, 32'h1 << b);
      apb(0, AC, 0);
      chk(rd, 32'h1 << b);
      chk(32'(irq), 1);
      chk(32'(fault_message), 1);
      for (int n = 0; n < 40 && asterisk !== 1'b1; n++) @(posedge pclk);
      chk(32'(asterisk), 1);
      for (int n = 0; n < 3000 && status_led !== 1'b1; n++) @(posedge pclk);
      chk(32'(status_led), 1);
      ev[b] <= 0;
      press(b[0]);
      chk(32'(fault_message), 0);
      chk(32'(asterisk), 0);
      apb(1, ST, 32'h1 << b);
      chk(32'(irq), 0);
      apb(0, AC, 0);
      chk(rd, 0);
    end
    apb(0, HC, 0);
    chk(rd, 5);
    apb(1, HS, 0);
    apb(0, HD, 0);
    chk(rd, {15'h0, 1'b1, fea_pkg::CODE_CHKSUM});
    $display("test events done");
  endtask
  task automatic t_xfer(input logic r);
    stall <= 1;
    if (r) rxs <= 1;
    else xs <= 1;
    @(posedge pclk);
    xs <= 0;
    rxs <= 0;
    repeat (60) @(posedge pclk);
    stall <= 0;
    repeat (10) @(posedge pclk);
    apb(0, AC, 0);
    chk(rd, 32'h1 << (fea_pkg::F_XFER + r));
    apb(1, MK, 0);
    chk(32'(irq), 0);
    apb(1, MK, 32'hff);
    chk(32'(irq), 1);
    press(!r);
    apb(0, AC, 0);
    chk(rd, 0);
    apb(1, ST, 32'hff);
    chk(32'(irq), 0);
    $display("test transfer done");
  endtask
  task automatic conclude();
    $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_reset();
    t_events();
    t_xfer(0);
    t_xfer(1);
    conclude();
  end
  // The limit is far above the few hundred cycles the tests need.
  initial begin
    #400000;
    miscompares++;
    conclude();
  end
endmodule
`default_nettype wire

// ==== testbench/fea_top_props.sv ====
// Purpose: Port-level checks for the fault event annunciator.
// Assumes: One clock domain; buttons are clean pulses.
// Notes:   Flash pulse widths are measured by helper counters.
`timescale 1ns/100ps
`default_nettype none
module fea_top_props #(
  parameter int unsigned PULSE_ON_CYCLES  = 4,
  parameter int unsigned PULSE_OFF_CYCLES = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic checksum_done,
  input wire logic checksum_mismatch,
  input wire logic charger_fault,
  input wire logic network_link_module_batt_low,
  input wire logic network_link_module_comm_lost,
  input wire logic reset_button,
  input wire logic override_button,
  input wire logic status_led,
  input wire logic fault_message,
  input wire logic irq
);
  logic [15:0] hi_cnt;
  logic [15:0] lo_cnt;
  // The low counter starts saturated so the first pulse after reset is not judged.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_cnt <= '0;
      lo_cnt <= '1;
    end else begin
      hi_cnt <= status_led ? hi_cnt + 16'h1 : 16'h0;
      lo_cnt <= status_led ? 16'h0 : ((lo_cnt == '1) ? lo_cnt : lo_cnt + 16'h1);
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_led_on_width: assert property ($fell(status_led) && fault_message && hi_cnt != 0
    |-> hi_cnt == PULSE_ON_CYCLES) else $error("flash pulse width wrong");
  a_led_off_gap: assert property ($rose(status_led) |-> lo_cnt >= PULSE_OFF_CYCLES)
    else $error("flash gap too short");
  a_reset_btn_ack: assert property ($rose(reset_button) |-> ##[1:4] !fault_message)
    else $error("reset button did not clear message");
  a_override_ack: assert property ($rose(override_button) |-> ##[1:4] !fault_message)
    else $error("override button did not clear message");
  a_charger_msg: assert property ($rose(charger_fault) |-> ##[1:8] fault_message)
    else $error("charger fault not shown");
  a_netbat_msg: assert property ($rose(network_link_module_batt_low)
    |-> ##[1:8] fault_message) else $error("network battery fault not shown");
  a_netcom_msg: assert property ($rose(network_link_module_comm_lost)
    |-> ##[1:8] fault_message) else $error("network link fault not shown");
  a_chksum_msg: assert property ($rose(checksum_done) && checksum_mismatch
    |-> ##[1:8] fault_message) else $error("checksum fault not shown");
  a_apb_answer: assert property (psel && penable |-> ##[0:4] pready)
    else $error("bus access not answered");
  c_flash: cover property ($rose(status_led));
  c_irq: cover property ($rose(irq));
  c_ack: cover property ($fell(fault_message));
endmodule
bind fea_top fea_top_props #(.PULSE_ON_CYCLES(PULSE_ON_CYCLES),
  .PULSE_OFF_CYCLES(PULSE_OFF_CYCLES)) u_fea_top_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .checksum_done(checksum_done),
  .checksum_mismatch(checksum_mismatch), .charger_fault(charger_fault),
  .network_link_module_batt_low(network_link_module_batt_low),
  .network_link_module_comm_lost(network_link_module_comm_lost),
  .reset_button(reset_button), .override_button(override_button),
  .status_led(status_led), .fault_message(fault_message), .irq(irq));
`default_nettype wire

// ==== verilog/fea_hist_mem.sv ====
// Purpose: Event history storage with registered read data.
// Assumes: One write and one read port on pclk.
// Notes:   Entries hold a fault flag and a BCD code.
`timescale 1ns/100ps
`default_nettype none
module fea_hist_mem #(
  parameter int unsigned DEPTH = 50,
  parameter int unsigned WIDTH = 17
) (
  input  wire logic                     pclk,
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input  wire logic [WIDTH-1:0]         wr_data,
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic      [WIDTH-1:0]         rd_data
);
  initial begin
    if (DEPTH < 2) begin
      $error("fea_hist_mem depth too small");
    end
  end
  logic [WIDTH-1:0] mem [DEPTH];
  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

// ==== verilog/fea_pkg.sv ====
// Purpose: Shared constants for the fault event annunciator.
// Assumes: 200 MHz pclk.
// Notes:   Timing figures are kept in their own units and converted here.
package fea_pkg;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned NUM_FAULTS = 8;
  localparam int unsigned HIST_DEPTH = 50;
  localparam int unsigned REG_OFS_STATUS = 32'h0;
  localparam int unsigned REG_OFS_MASK = 32'h4;
  localparam int unsigned REG_OFS_ACTIVE = 32'h8;
  localparam int unsigned REG_OFS_CTRL = 32'hc;
  localparam int unsigned REG_OFS_HCOUNT = 32'h10;
  localparam int unsigned REG_OFS_HSEL = 32'h14;
  localparam int unsigned REG_OFS_HDATA = 32'h18;
  localparam int unsigned REG_OFS_FTC = 32'h1c;
  localparam logic [31:0] FTC_RESET = 32'h0098_9680;
  localparam int unsigned PULSE_ON_US = 250;
  localparam int unsigned PULSE_OFF_US = 250;
  localparam int unsigned DIGIT_GAP_US = 1000;
  localparam int unsigned CODE_GAP_US = 3000;
  localparam int unsigned BLINK_MS = 500;
  localparam int unsigned PULSE_ON_CYC = PULSE_ON_US * CLK_MHZ;
  localparam int unsigned PULSE_OFF_CYC = PULSE_OFF_US * CLK_MHZ;
  localparam int unsigned DIGIT_GAP_CYC = DIGIT_GAP_US * CLK_MHZ;
  localparam int unsigned CODE_GAP_CYC = CODE_GAP_US * CLK_MHZ;
  localparam int unsigned BLINK_CYC = BLINK_MS * 1000 * CLK_MHZ;
  // Fault index order is also the flash rotation order, index 0 first after reset.
  localparam int unsigned F_CHKSUM = 0;
  localparam int unsigned F_CTLBAT = 1;
  localparam int unsigned F_XFER = 2;
  localparam int unsigned F_RETX = 3;
  localparam int unsigned F_CHARGER = 4;
  localparam int unsigned F_NETBAT = 5;
  localparam int unsigned F_NETCOM = 6;
  localparam int unsigned F_NONFAULT = 7;
  localparam logic [15:0] CODE_CHKSUM = 16'h0343;
  localparam logic [15:0] CODE_CTLBAT = 16'h0441;
  localparam logic [15:0] CODE_XFER = 16'h1113;
  localparam logic [15:0] CODE_RETX = 16'h1114;
  localparam logic [15:0] CODE_CHARGER = 16'h0597;
  localparam logic [15:0] CODE_NETBAT = 16'h0477;
  localparam logic [15:0] CODE_NETCOM = 16'h1468;
  localparam logic [15:0] CODE_NONFAULT = 16'h0000;
  typedef enum logic [2:0] {FEA_IDLE, FEA_ON, FEA_OFF, FEA_DGAP, FEA_CGAP} fea_flash_e;
  typedef enum logic [2:0] {FEA_X_IDLE, FEA_X_LEG1, FEA_X_LEG2} fea_xfer_e;
endpackage

// ==== verilog/fea_top.sv ====
// Purpose: Fault supervision, event history and status indicator flash-out.
// Assumes: All status inputs are asynchronous pins; pushbuttons are debounced.
// Notes:   Codes are BCD, flashed most significant digit first.
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
module fea_top #(
  parameter int unsigned DEPTH = fea_pkg::HIST_DEPTH,
  parameter int unsigned CODE_GAP_CYCLES = fea_pkg::CODE_GAP_CYC,
  parameter int unsigned DIGIT_GAP_CYCLES = fea_pkg::DIGIT_GAP_CYC,
  parameter int unsigned PULSE_ON_CYCLES = fea_pkg::PULSE_ON_CYC,
  parameter int unsigned PULSE_OFF_CYCLES = fea_pkg::PULSE_OFF_CYC,
  parameter int unsigned BLINK_CYCLES = fea_pkg::BLINK_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        checksum_done,
  input  wire logic        checksum_mismatch,
  input  wire logic        ctl_battery_low,
  input  wire logic        charger_fault,
  input  wire logic        network_link_module_batt_low,
  input  wire logic        network_link_module_comm_lost,
  input  wire logic        pos_source1,
  input  wire logic        pos_neutral,
  input  wire logic        pos_source2,
  input  wire logic        transfer_start,
  input  wire logic        retransfer_start,
  input  wire logic        reset_button,
  input  wire logic        override_button,
  output logic             status_led,
  output logic             fault_message,
  output logic             asterisk,
  output logic             irq
);
  localparam int unsigned NF = fea_pkg::NUM_FAULTS;
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned NSYNC = 13;
  initial begin
    if (DEPTH < 2 || DEPTH > 255 || CODE_GAP_CYCLES < PULSE_OFF_CYCLES || PULSE_ON_CYCLES < 1 ||
        DIGIT_GAP_CYCLES < 1 || PULSE_OFF_CYCLES < 1 || BLINK_CYCLES < 1) begin
      $error("fea_top parameters out of range");
    end
  end

  typedef struct packed {
    logic [NSYNC-1:0] s1;
    logic [NSYNC-1:0] s2;
    logic [NSYNC-1:0] s2_q;
    logic [NF-1:0]    pend;
    logic [NF-1:0]    stat;
    logic [NF-1:0]    mask;
    logic [NF-1:0]    latch;
    logic             chk_seen;
    fea_pkg::fea_xfer_e xst;
    logic             xdir;
    logic [31:0]      xcnt;
    logic [31:0]      ftc;
    fea_pkg::fea_flash_e fst;
    logic [2:0]       fidx;
    logic [1:0]       dig;
    logic [3:0]       pulses;
    logic [31:0]      tcnt;
    logic [31:0]      bcnt;
    logic             blink;
    logic [AW-1:0]    wptr;
    logic [7:0]       hcount;
    logic [AW-1:0]    hsel;
    logic [2:0]       lidx;
    logic             lreq;
    logic [31:0]      rdata;
    logic [NF-1:0]    act_q;
    logic [NF-1:0]    lpend;
  } fea_state_s;

  fea_state_s st;
  fea_state_s next_st;
  logic [16:0] hrd;
  logic [16:0] hwd;
  logic [NF-1:0] active;
  logic [NF-1:0] rise;
  logic        ack;
  logic        wr;
  logic        clr;
  logic [15:0] code;

  function automatic logic [15:0] code_of(input logic [2:0] i);
    case (i)
      3'd0:    code_of = fea_pkg::CODE_CHKSUM;
      3'd1:    code_of = fea_pkg::CODE_CTLBAT;
      3'd2:    code_of = fea_pkg::CODE_XFER;
      3'd3:    code_of = fea_pkg::CODE_RETX;
      3'd4:    code_of = fea_pkg::CODE_CHARGER;
      3'd5:    code_of = fea_pkg::CODE_NETBAT;
      3'd6:    code_of = fea_pkg::CODE_NETCOM;
      default: code_of = fea_pkg::CODE_NONFAULT;
    endcase
  endfunction

  // Slot 7 is a non-fault event slot: logged, never flashed or on the interrupt, but it can light the asterisk.
  assign hwd = {st.lidx != 3'(fea_pkg::F_NONFAULT), code_of(st.lidx)};
  assign code = code_of(st.fidx);

  fea_hist_mem #(
    .DEPTH (DEPTH),
    .WIDTH (17)
  ) u_hist (
    .pclk    (pclk),
    .wr_en   (st.lreq),
    .wr_addr (st.wptr),
    .wr_data (hwd),
    .rd_addr (st.hsel),
    .rd_data (hrd)
  );

  always_comb begin
    logic [2:0] pick;
    logic [3:0] dval;
    logic [2:0] fpick;
    logic [15:0] cw;
    pick = 3'd0;
    dval = 4'd0;
    fpick = 3'd0;
    cw = 16'h0;
    next_st = st;
    next_st.s1 = {network_link_module_comm_lost, network_link_module_batt_low, charger_fault,
                  ctl_battery_low, checksum_mismatch, checksum_done, pos_source1, pos_neutral,
                  pos_source2, transfer_start, retransfer_start, reset_button, override_button};
    next_st.s2 = st.s1;
    next_st.s2_q = st.s2;
    wr = psel && penable && pwrite;
    ack = (st.s2[1] && !st.s2_q[1]) || (st.s2[0] && !st.s2_q[0]);

    // One check per reset: the strobe is only caught once.
    active = '0;
    if (st.s2[7] && !st.chk_seen) begin
      next_st.chk_seen = 1'b1;
      if (st.s2[8]) begin
        next_st.latch[fea_pkg::F_CHKSUM] = 1'b1;
      end
    end
    active[fea_pkg::F_CHKSUM] = st.latch[fea_pkg::F_CHKSUM];
    active[fea_pkg::F_CTLBAT] = st.s2[9];
    active[fea_pkg::F_CHARGER] = st.s2[10];
    active[fea_pkg::F_NETBAT] = st.s2[11];
    active[fea_pkg::F_NETCOM] = st.s2[12];
    active[fea_pkg::F_XFER] = st.latch[fea_pkg::F_XFER];
    active[fea_pkg::F_RETX] = st.latch[fea_pkg::F_RETX];
    active[fea_pkg::F_NONFAULT] = st.s2[3] || st.s2[2];

    // Fail-to-close supervision of both legs.
    case (st.xst)
      fea_pkg::FEA_X_IDLE: begin
        next_st.xcnt = '0;
        if (st.s2[3] || st.s2[2]) begin
          next_st.xdir = st.s2[2];
          next_st.xst = fea_pkg::FEA_X_LEG1;
        end
      end
      fea_pkg::FEA_X_LEG1: begin
        next_st.xcnt = st.xcnt + 32'h1;
        if (st.s2[5]) begin
          next_st.xcnt = '0;
          next_st.xst = fea_pkg::FEA_X_LEG2;
        end else if (st.xcnt >= st.ftc) begin
          next_st.latch[st.xdir ? fea_pkg::F_RETX : fea_pkg::F_XFER] = 1'b1;
          next_st.xst = fea_pkg::FEA_X_IDLE;
        end
      end
      fea_pkg::FEA_X_LEG2: begin
        next_st.xcnt = st.xcnt + 32'h1;
        if (st.xdir ? st.s2[6] : st.s2[4]) begin
          next_st.xst = fea_pkg::FEA_X_IDLE;
        end else if (st.xcnt >= st.ftc) begin
          next_st.latch[st.xdir ? fea_pkg::F_RETX : fea_pkg::F_XFER] = 1'b1;
          next_st.xst = fea_pkg::FEA_X_IDLE;
        end
      end
      default: next_st.xst = fea_pkg::FEA_X_IDLE;
    endcase
    if (ack) begin
      next_st.latch = next_st.latch & ~st.latch;
    end

    // Only a rising active bit opens a pending entry, so a lasting fault does not flash or raise fault_message again after ack.
    rise = active & ~st.act_q;
    next_st.act_q = active;
    clr = ack || (wr && paddr == 8'(fea_pkg::REG_OFS_CTRL) && pwdata[0]);
    // A new event in the acknowledge cycle still wins over the clear.
    next_st.pend = (clr ? '0 : st.pend) | (rise & {1'b0, {(NF-1){1'b1}}});
    next_st.stat = st.stat | active;
    if (wr && paddr == 8'(fea_pkg::REG_OFS_STATUS)) begin
      next_st.stat = (st.stat & ~pwdata[NF-1:0]) | active;
    end
    if (wr && paddr == 8'(fea_pkg::REG_OFS_MASK)) begin
      next_st.mask = pwdata[NF-1:0];
    end
    if (wr && paddr == 8'(fea_pkg::REG_OFS_HSEL) && pwdata < 32'(DEPTH)) begin
      next_st.hsel = pwdata[AW-1:0];
    end
    if (wr && paddr == 8'(fea_pkg::REG_OFS_FTC)) begin
      next_st.ftc = pwdata;
    end
    if (wr && paddr == 8'(fea_pkg::REG_OFS_CTRL) && pwdata[0]) begin
      next_st.latch = next_st.latch & ~st.latch;
    end

    // Several events may rise together; they queue and are logged one per cycle.
    next_st.lreq = 1'b0;
    for (int i = NF - 1; i >= 0; i--) begin
      if (st.lpend[i]) begin
        pick = 3'(i);
      end
    end
    next_st.lpend = st.lpend;
    if (|st.lpend) begin
      next_st.lidx = pick;
      next_st.lreq = 1'b1;
      next_st.lpend[pick] = 1'b0;
    end
    next_st.lpend = next_st.lpend | rise;

    // The ring overwrites its oldest entry once full.
    if (st.lreq) begin
      next_st.wptr = (st.wptr == AW'(DEPTH - 1)) ? '0 : st.wptr + AW'(1);
      if (st.hcount != 8'(DEPTH)) begin
        next_st.hcount = st.hcount + 8'h1;
      end
    end

    if (st.bcnt >= 32'(BLINK_CYCLES - 1)) begin
      next_st.bcnt = 32'h0;
      next_st.blink = !st.blink;
    end else begin
      next_st.bcnt = st.bcnt + 32'h1;
    end

    // Flash-out: one pulse per unit of a digit, short gaps between digits, a long one before
    // each repetition. The next pending fault is picked after the current one in fixed order.
    next_st.tcnt = (st.tcnt != 32'h0) ? st.tcnt - 32'h1 : 32'h0;
    fpick = st.fidx;
    for (int k = NF - 1; k >= 1; k--) begin
      if (st.pend[(int'(st.fidx) + k) % (NF - 1)]) begin
        fpick = 3'((int'(st.fidx) + k) % (NF - 1));
      end
    end
    case (st.fst)
      fea_pkg::FEA_IDLE: begin
        if (|st.pend) begin
          next_st.fst = fea_pkg::FEA_CGAP;
          next_st.tcnt = 32'(CODE_GAP_CYCLES - 1);
        end
      end
      fea_pkg::FEA_CGAP: begin
        if (st.tcnt == 32'h0) begin
          cw = code_of(fpick);
          dval = cw[15:12];
          next_st.fidx = fpick;
          next_st.dig = 2'd3;
          if (!(|st.pend)) begin
            next_st.fst = fea_pkg::FEA_IDLE;
          end else if (dval == 4'd0) begin
            next_st.fst = fea_pkg::FEA_DGAP;
            next_st.tcnt = 32'(DIGIT_GAP_CYCLES - 1);
          end else begin
            next_st.fst = fea_pkg::FEA_ON;
            next_st.pulses = dval;
            next_st.tcnt = 32'(PULSE_ON_CYCLES - 1);
          end
        end
      end
      fea_pkg::FEA_ON: begin
        if (st.tcnt == 32'h0) begin
          if (st.pulses > 4'd1) begin
            next_st.fst = fea_pkg::FEA_OFF;
            next_st.pulses = st.pulses - 4'd1;
            next_st.tcnt = 32'(PULSE_OFF_CYCLES - 1);
          end else begin
            next_st.fst = fea_pkg::FEA_DGAP;
            next_st.tcnt = 32'(DIGIT_GAP_CYCLES - 1);
          end
        end
      end
      fea_pkg::FEA_OFF: begin
        if (st.tcnt == 32'h0) begin
          next_st.fst = fea_pkg::FEA_ON;
          next_st.tcnt = 32'(PULSE_ON_CYCLES - 1);
        end
      end
      fea_pkg::FEA_DGAP: begin
        if (st.tcnt == 32'h0) begin
          cw = code >> {st.dig - 2'd1, 2'b00};
          dval = cw[3:0];
          if (st.dig == 2'd0) begin
            next_st.fst = fea_pkg::FEA_CGAP;
            next_st.tcnt = 32'(CODE_GAP_CYCLES - 1);
          end else if (dval == 4'd0) begin
            next_st.dig = st.dig - 2'd1;
            next_st.tcnt = 32'(DIGIT_GAP_CYCLES - 1);
          end else begin
            next_st.dig = st.dig - 2'd1;
            next_st.fst = fea_pkg::FEA_ON;
            next_st.pulses = dval;
            next_st.tcnt = 32'(PULSE_ON_CYCLES - 1);
          end
        end
      end
      default: begin
        next_st.fst = fea_pkg::FEA_IDLE;
      end
    endcase
    if (clr) begin
      next_st.fst = fea_pkg::FEA_IDLE;
    end

    // Read data is captured in the setup cycle and stands through the access phase.
    if (psel && !penable) begin
      case (paddr)
        8'(fea_pkg::REG_OFS_STATUS): next_st.rdata = 32'(st.stat);
        8'(fea_pkg::REG_OFS_MASK):   next_st.rdata = 32'(st.mask);
        8'(fea_pkg::REG_OFS_ACTIVE): next_st.rdata = 32'(active);
        8'(fea_pkg::REG_OFS_HCOUNT): next_st.rdata = 32'(st.hcount);
        8'(fea_pkg::REG_OFS_HSEL):   next_st.rdata = 32'(st.hsel);
        8'(fea_pkg::REG_OFS_HDATA):  next_st.rdata = 32'(hrd);
        8'(fea_pkg::REG_OFS_FTC):    next_st.rdata = st.ftc;
        default:                     next_st.rdata = 32'h0;
      endcase
    end
  end

  assign prdata = st.rdata;
  assign pready = psel && penable;
  assign pslverr = psel && penable && (paddr[1:0] != 2'h0 || paddr > 8'(fea_pkg::REG_OFS_FTC));
  assign status_led = (st.fst == fea_pkg::FEA_ON);
  assign fault_message = |st.pend;
  assign asterisk = st.blink && (|st.act_q);
  // The non-fault slot is logged and can light the asterisk; it never raises the interrupt.
  assign irq = |(st.stat & st.mask & {1'b0, {(NF-1){1'b1}}});

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.ftc <= fea_pkg::FTC_RESET;
      st.fidx <= 3'(NF - 2);
    end else begin
      st <= next_st;
    end
  end
endmodule
`default_nettype wire
